// ==== rtl/bpct_pkg.sv ====
`default_nettype none
package bpct_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PRESC = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_T2 = 8'h10;
  localparam logic [7:0] OFS_T3 = 8'h14;
  localparam logic [7:0] OFS_T4 = 8'h18;
  localparam logic [7:0] OFS_T5 = 8'h1C;
  localparam logic [7:0] OFS_T6 = 8'h20;
  // Control field positions
  localparam int CTRL_RUN1 = 0;
  localparam int CTRL_RUN2 = 1;
  localparam int CTRL_DN1 = 2;
  localparam int CTRL_DN2 = 3;
  localparam int CTRL_CHA = 4;
  localparam int CTRL_CHB = 5;
  localparam int CTRL_CHC = 6;
  // Prescale field positions
  localparam int PS_FIRST_BLOCK_PRESCALE = 0;
  localparam int PS_SECOND_BLOCK_PRESCALE = 2;
  localparam int PS_IND1 = 4;
  localparam int PS_IND2 = 8;
  // Status bit positions
  localparam int ST_OV1 = 0;
  localparam int ST_OV2 = 1;
  localparam int ST_AUX = 2;
  // Reset values
  localparam logic [1:0] BPS_RST = 2'h0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // Basic clock periods in system clocks for encodings 00,01,10,11
  localparam logic [5:0] B1_DIV00 = 6'h08;
  localparam logic [5:0] B1_DIV01 = 6'h04;
  localparam logic [5:0] B1_DIV10 = 6'h20;
  localparam logic [5:0] B1_DIV11 = 6'h10;
  localparam logic [5:0] B2_DIV00 = 6'h04;
  localparam logic [5:0] B2_DIV01 = 6'h02;
  localparam logic [5:0] B2_DIV10 = 6'h10;
  localparam logic [5:0] B2_DIV11 = 6'h08;
  typedef struct packed {
    logic [2:0] ind2;
    logic [2:0] ind1;
    logic [1:0] second_block_prescale;
    logic [1:0] first_block_prescale;
  } bpct_presc_s;
endpackage : bpct_pkg
`default_nettype wire

// ==== rtl/bpct_timers.sv ====
// Summary of operation
// - Each block clocked by its own prescaler
// - Block prescalers reset to encoding 00
// - First block: two basics 8/16/32/64 clocks; the code gives basic periods of 4/8/16/32 clocks
// - Second block: two basics 4/8/16/32 clocks; the code gives basic periods of 2/4/8/16 clocks
// - Core is low part, auxiliary high
// - Aux steps on core wrap, within two
// - Chaining only inside the same block
// - Trigger modes: counter, interface, capture, reload; only internal timer mode is built
//
// Added by the designer: register access over APB and the address map.
`default_nettype none
module bpct_timers
  import bpct_pkg::*;
#(
  parameter int TW = 16
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic irq // Interrupt level
);
  // Register state
  logic [31:0] ctrl_r; // Run, direction and chain bits
  bpct_presc_s presc_r; // Block and individual prescalers
  logic [2:0] status_r; // Sticky event flags
  logic [2:0] mask_r; // Interrupt mask
  logic [TW-1:0] tmr_r [5]; // 0:aux a,1:core1,2:aux b,3:aux2,4:core2
  // Block prescaler chain
  logic [5:0] bdiv1_r; // First block divider
  logic [5:0] bdiv2_r; // Second block divider
  logic [5:0] half1; // First block basic period
  logic [5:0] half2; // Second block basic period
  logic b1_tick; // First block basic clock
  logic b2_tick; // Second block basic clock
  // Individual prescaler chain
  logic [6:0] ip1_r; // First core basic clock count
  logic [6:0] ip2_r; // Second core basic clock count
  logic [6:0] ip1_mask; // First core divide mask
  logic [6:0] ip2_mask; // Second core divide mask
  logic c1_tick; // First core count clock
  logic c2_tick; // Second core count clock
  // Chain events
  logic c1_wrap; // First core overflow or underflow
  logic c2_wrap; // Second core overflow or underflow
  logic c1_wrap_r; // First core event, registered
  logic c2_wrap_r; // Second core event, registered
  // Bus decode
  logic setup; // Setup phase of a transfer
  logic wr_en; // Write access phase
  logic rd_en; // Read access phase
  logic addr_ok; // Address is mapped
  logic [31:0] rd_mux; // Read data selection
  logic irq_r; // Interrupt level

  // First block basic period for each prescaler encoding
  always_comb begin
    case (presc_r.first_block_prescale)
      2'h0: half1 = B1_DIV00;
      2'h1: half1 = B1_DIV01;
      2'h2: half1 = B1_DIV10;
      default: half1 = B1_DIV11;
    endcase
  end

  // Second block basic period for each prescaler encoding
  always_comb begin
    case (presc_r.second_block_prescale)
      2'h0: half2 = B2_DIV00;
      2'h1: half2 = B2_DIV01;
      2'h2: half2 = B2_DIV10;
      default: half2 = B2_DIV11;
    endcase
  end

  // One basic clock tick per basic period
  assign b1_tick = (bdiv1_r == half1 - 6'h01);
  assign b2_tick = (bdiv2_r == half2 - 6'h01);

  // First block divider; a shorter new period restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bdiv1_r <= 6'h00;
    end else if (b1_tick || bdiv1_r >= half1) begin
      bdiv1_r <= 6'h00;
    end else begin
      bdiv1_r <= bdiv1_r + 6'h01;
    end
  end

  // Second block divider; a shorter new period restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bdiv2_r <= 6'h00;
    end else if (b2_tick || bdiv2_r >= half2) begin
      bdiv2_r <= 6'h00;
    end else begin
      bdiv2_r <= bdiv2_r + 6'h01;
    end
  end

  // Individual prescalers divide the basic clock by a power of two
  assign ip1_mask = (7'h01 << presc_r.ind1) - 7'h01;
  assign ip2_mask = (7'h01 << presc_r.ind2) - 7'h01;
  assign c1_tick = b1_tick && ((ip1_r & ip1_mask) == 7'h00);
  assign c2_tick = b2_tick && ((ip2_r & ip2_mask) == 7'h00);

  // First core basic clock count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ip1_r <= 7'h00;
    end else if (b1_tick) begin
      ip1_r <= ip1_r + 7'h01;
    end
  end

  // Second core basic clock count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ip2_r <= 7'h00;
    end else if (b2_tick) begin
      ip2_r <= ip2_r + 7'h01;
    end
  end

  // Core wrap in the counting direction; only internal timer mode
  // exists, so no trigger mode is open to spurious events
  assign c1_wrap = c1_tick && ctrl_r[CTRL_RUN1] &&
    (ctrl_r[CTRL_DN1] ? (tmr_r[1] == '0) : (tmr_r[1] == '1));
  assign c2_wrap = c2_tick && ctrl_r[CTRL_RUN2] &&
    (ctrl_r[CTRL_DN2] ? (tmr_r[4] == '0) : (tmr_r[4] == '1));

  // APB phase decode
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  // Mapped addresses
  always_comb begin
    case (paddr)
      OFS_CTRL, OFS_PRESC, OFS_STATUS, OFS_MASK, OFS_T2, OFS_T3, OFS_T4, OFS_T5,
      OFS_T6: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_en && paddr == OFS_CTRL) begin
      ctrl_r <= {25'h0, pwdata[6:0]};
    end
  end

  // Prescale register; bit 7 is unused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r <= '{ind2: 3'h0, ind1: 3'h0, second_block_prescale: BPS_RST, first_block_prescale: BPS_RST};
    end else if (wr_en && paddr == OFS_PRESC) begin
      presc_r <= {pwdata[10:8], pwdata[6:4], pwdata[3:2], pwdata[1:0]};
    end
  end

  // Interrupt mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= 3'h0;
    end else if (wr_en && paddr == OFS_MASK) begin
      mask_r <= pwdata[2:0];
    end
  end

  // First block chain event: aux steps one cycle after core wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_wrap_r <= 1'b0;
    end else begin
      c1_wrap_r <= c1_wrap;
    end
  end

  // Second block chain event: aux steps one cycle after core wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c2_wrap_r <= 1'b0;
    end else begin
      c2_wrap_r <= c2_wrap;
    end
  end

  // Timer updates: cores count, aux timers follow their block core
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_tmr
      logic wsel;
      logic step;
      logic dn;
      logic chained;
      assign wsel = wr_en && (paddr == OFS_T2 + 8'(4 * gi));
      // Step source and direction per timer
      always_comb begin
        case (gi)
          0: begin
            chained = ctrl_r[CTRL_CHA];
            step = c1_wrap_r;
            dn = ctrl_r[CTRL_DN1];
          end
          1: begin
            chained = 1'b1;
            step = c1_tick && ctrl_r[CTRL_RUN1];
            dn = ctrl_r[CTRL_DN1];
          end
          2: begin
            chained = ctrl_r[CTRL_CHB];
            step = c1_wrap_r;
            dn = ctrl_r[CTRL_DN1];
          end
          3: begin
            chained = ctrl_r[CTRL_CHC];
            step = c2_wrap_r;
            dn = ctrl_r[CTRL_DN2];
          end
          default: begin
            chained = 1'b1;
            step = c2_tick && ctrl_r[CTRL_RUN2];
            dn = ctrl_r[CTRL_DN2];
          end
        endcase
      end
      // Software write wins over a count step
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tmr_r[gi] <= '0;
        end else if (wsel) begin
          tmr_r[gi] <= pwdata[TW-1:0];
        end else if (chained && step) begin
          tmr_r[gi] <= dn ? tmr_r[gi] - 1'b1 : tmr_r[gi] + 1'b1;
        end
      end
    end
  endgenerate

  // Sticky status, cleared by read; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= 3'h0;
    end else begin
      status_r <= ((rd_en && paddr == OFS_STATUS) ? 3'h0 : status_r) |
        {c1_wrap_r | c2_wrap_r, c2_wrap, c1_wrap};
    end
  end

  // Interrupt level, one cycle behind the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & mask_r);
    end
  end
  assign irq = irq_r;

  // Read data selection
  always_comb begin
    case (paddr)
      OFS_CTRL: rd_mux = ctrl_r;
      OFS_PRESC: rd_mux = {21'h0, presc_r.ind2, 1'b0, presc_r.ind1,
        presc_r.second_block_prescale, presc_r.first_block_prescale};
      OFS_STATUS: rd_mux = {29'h0, status_r};
      OFS_MASK: rd_mux = {29'h0, mask_r};
      OFS_T2: rd_mux = 32'(tmr_r[0]);
      OFS_T3: rd_mux = 32'(tmr_r[1]);
      OFS_T4: rd_mux = 32'(tmr_r[2]);
      OFS_T5: rd_mux = 32'(tmr_r[3]);
      OFS_T6: rd_mux = 32'(tmr_r[4]);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Ready pulse in the access phase, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // Error reply on an unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && !addr_ok;
    end
  end

  // Read data, sampled in the setup phase, zero otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= rd_mux;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end
endmodule : bpct_timers
`default_nettype wire

// ==== bench/bpct_properties.sv ====
`default_nettype none
module bpct_properties (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Write
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Wdata
  input wire logic [31:0] prdata, // Rdata
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic irq // Irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus answer timing, error replies and interrupt masking
  AST_RDY_NEXT: assert property (psel && !penable |=> pready) else $error("no ready");
  AST_RDY_PULSE: assert property (pready |=> !pready) else $error("ready held");
  AST_RDY_ACC: assert property (pready |-> psel && penable) else $error("stray ready");
  AST_ERR_RDY: assert property (pslverr |-> pready) else $error("stray error");
  AST_ERR_DATA: assert property (pslverr |-> prdata == '0) else $error("error data");
  AST_UNMAP: assert property (psel && !penable && paddr > 8'h20 |=> pslverr)
    else $error("no error");
  AST_MAP: assert property (psel && !penable && paddr < 8'h24 && paddr[1:0] == 2'h0
    |=> !pslverr) else $error("bad error");
  AST_IRQ_MASK: assert property (pready && pwrite && paddr == 8'h0C && pwdata == '0
    |=> ##1 !irq) else $error("irq unmasked");
  // Main scenarios
  COV_ERR: cover property (pslverr);
  COV_IRQ: cover property (irq ##1 !irq);
  COV_B2B: cover property (pready ##1 psel && !penable);
endmodule : bpct_properties
bind bpct_timers bpct_properties i_bpct_properties (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);
`default_nettype wire

// ==== bench/bpct_timers_tb_top.sv ====
`default_nettype none
module bpct_timers_tb_top
  import bpct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, er;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  int failures = 0, check_count = 0;
  bpct_timers i_bpct_timers (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq);
  // Clock, 8 ns period
  always #4 pclk = ~pclk;
  task automatic summarize;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  // One transfer, request held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) begin
      failures++;
      summarize();
    end
    @(posedge pclk);
  endtask : apb
  // Core advance over 4*p clocks, eight count periods of p/2 clocks
  task automatic meas(input logic [31:0] pv, input logic [7:0] a, input int p);
    logic [31:0] q0;
    apb(1'h1, OFS_PRESC, pv);
    apb(1'h0, a, 32'h0);
    q0 = q;
    repeat (4 * p - 3) @(posedge pclk);
    apb(1'h0, a, 32'h0);
    chk("count step", (q - q0) & 32'hFFFF, 32'h8);
  endtask : meas
  task automatic t_reset;
    apb(1'h0, OFS_PRESC, 32'h0);
    chk("presc reset", q & 32'hF, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_presc;
    int p1[4] = '{16, 8, 64, 32};
    int p2[4] = '{8, 4, 32, 16};
    apb(1'h1, OFS_CTRL, 32'h3);
    for (int i = 0; i < 4; i++) begin
      meas(32'(i) << PS_FIRST_BLOCK_PRESCALE, OFS_T3, p1[i]);
      meas(32'(i) << PS_SECOND_BLOCK_PRESCALE, OFS_T6, p2[i]);
    end
    meas(32'h1 << PS_IND1, OFS_T3, 32);
    apb(1'h0, OFS_STATUS, 32'h0);
    $display("test prescale done");
  endtask : t_presc
  task automatic t_chain;
    logic [7:0] wa[5] = '{OFS_T2, OFS_T3, OFS_T4, OFS_T5, OFS_T6};
    logic [31:0] wv[5] = '{32'h5, 32'hFFFE, 32'h9, 32'h3, 32'h1};
    logic [31:0] hi;
    apb(1'h1, OFS_CTRL, 32'h0);
    apb(1'h1, OFS_PRESC, 32'h5);
    apb(1'h1, OFS_MASK, 32'h1 << ST_AUX);
    for (int i = 0; i < 5; i++) apb(1'h1, wa[i], wv[i]);
    apb(1'h1, OFS_CTRL, 32'h5B);
    repeat (40) @(posedge pclk);
    apb(1'h1, OFS_CTRL, 32'h0);
    apb(1'h0, OFS_T2, 32'h0);
    hi = q;
    apb(1'h0, OFS_T3, 32'h0);
    repeat (8) @(posedge pclk);
    apb(1'h0, OFS_T2, 32'h0);
    chk("high stable", q, hi);
    chk("aux a value", q, 32'h6);
    apb(1'h0, OFS_T4, 32'h0);
    chk("aux b value", q, 32'h9);
    apb(1'h0, OFS_T5, 32'h0);
    chk("aux2 value", q, 32'h2);
    chk("irq set", irq, 32'h1);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk("aux flag", q[ST_AUX], 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq clear", irq, 32'h0);
    apb(1'h1, OFS_MASK, 32'h0);
    $display("test chain done");
  endtask : t_chain
  task automatic t_unmap;
    apb(1'h1, 8'h40, 32'hFFFF_FFFF);
    chk("write err", er, 32'h1);
    apb(1'h0, 8'h40, 32'h0);
    chk("read err", er, 32'h1);
    chk("read data", q, 32'h0);
    $display("test unmapped done");
  endtask : t_unmap
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset();
    t_presc();
    t_chain();
    t_unmap();
    summarize();
  end
endmodule : bpct_timers_tb_top
`default_nettype wire
